// ### verilog/bcd_pkg.sv
/*
 * Shared constants and carrier types for the brushless commutation decoder.
 * Assumes a single 10 MHz clock and an Avalon-MM slave port with 32-bit data.
 */
package bcd_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [3:0]  BCD_OFS_CTRL     = 4'h0;
	localparam logic [3:0]  BCD_OFS_STATUS   = 4'h4;
	localparam logic [3:0]  BCD_OFS_DRIVE    = 4'h8;

	// ==========================================================
	// Control register fields
	localparam int          BCD_CTRL_EN_BIT  = 0;
	localparam int          BCD_CTRL_BRK_BIT = 1;
	localparam int          BCD_CTRL_DIR_BIT = 2;
	localparam int          BCD_CTRL_SEL_BIT = 3;
	localparam int          BCD_CTRL_USE_BIT = 4;
	// Defaults match open input pins: enable high, brake high
	localparam logic [4:0]  BCD_CTRL_RESET   = 5'h03;

	// Status register fields
	localparam int          BCD_ST_FAULT_BIT = 0;
	localparam int          BCD_ST_INV_BIT   = 1;
	localparam int          BCD_ST_SECT_LSB  = 4;

	// ==========================================================
	// Drive levels
	localparam logic [2:0]  BCD_TOP_ALL_OFF  = 3'h7;
	localparam logic [2:0]  BCD_BOT_ALL_OFF  = 3'h0;
	localparam logic [2:0]  BCD_BOT_ALL_ON   = 3'h7;
	localparam logic [2:0]  BCD_SECT_NONE    = 3'h7;

	// Hall pins idle high through the internal pull-ups
	localparam logic [2:0]  BCD_HALL_RESET   = 3'h7;

	typedef struct packed {
		logic a;
		logic b;
		logic c;
	} bcd_phase_t;

	typedef struct packed {
		bcd_phase_t top_n;
		bcd_phase_t bot;
		logic       fault_n;
	} bcd_drive_t;

	typedef struct packed {
		logic        overcurrent;
		logic        undervoltage;
		logic        overtemp;
	} bcd_prot_t;

endpackage : bcd_pkg

// ### verilog/bcd_decoder.sv
/*
 * Rotor position decoder and six-step drive logic with brake interlock.
 * Assumes hall, control and protection inputs synchronous to clock.
 */
// Operation
// - Fault low on invalid, disable, overcurrent, undervoltage, overtemperature
// - Select high picks 60, low 120
// - Brake low allows run; high brakes
// - Eight codes, six valid, two invalid
// - Each valid code a distinct 60 degree sector
// - Reverse swaps top and bottom per phase
// - Enable defaults high when unconnected
// - Disabled: tops off, bottoms low, fault
// - Brake: tops off, all bottoms on
// - Brake outranks every other input
// - Brake defaults high when unconnected
// - Bottoms wait until all tops off
// - Interlock uses internal top controls
// - Unconnected hall input reads high
// - Top drives and fault active low
// - Invalid code, no brake: all off, fault
// - Overcurrent ends conduction for oscillator cycle
`timescale 1ns/1ps

module bcd_decoder
	import bcd_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire logic                  hall_input_a,
	input  wire logic                  hall_input_b,
	input  wire logic                  hall_input_c,
	input  wire logic                  hall_a_conn,
	input  wire logic                  hall_b_conn,
	input  wire logic                  hall_c_conn,
	input  wire logic                  phasing_60_sel,
	input  wire logic                  forward_sel,
	input  wire logic                  run_enable,
	input  wire logic                  run_enable_conn,
	input  wire logic                  brake_in,
	input  wire logic                  brake_conn,
	input  wire logic                  osc_cycle_start,
	input  wire bcd_pkg::bcd_prot_t    prot,
	input  wire logic [3:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	output logic                       phase_a_high_side_drive,
	output logic                       phase_b_high_side_drive,
	output logic                       phase_c_high_side_drive,
	output logic                       phase_a_low_side_drive,
	output logic                       phase_b_low_side_drive,
	output logic                       phase_c_low_side_drive,
	output logic                       fault_n
);
	import bcd_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [4:0]  ctrl;
		logic        oc_latch;
		logic        ack;
		logic [31:0] rdata;
		logic [2:0]  sector;
		logic        invalid;
		bcd_drive_t  drv;
	} bcd_state_t;

	bcd_state_t st_r;
	bcd_state_t st_nxt;

	logic [2:0]  hall;
	logic        en_eff;
	logic        brk_eff;
	logic        dir_eff;
	logic        sel_eff;
	logic        use_sw;
	logic [2:0]  sect;
	logic        valid;
	bcd_phase_t  top_on;
	bcd_phase_t  bot_on;
	bcd_phase_t  top_n_int;
	bcd_phase_t  bot_int;
	logic        oc_now;
	logic        fault_now;
	logic        bus_go;

	// Sector lookup for 60 degree phasing, indexed by code
	function automatic logic [3:0] bcd_dec60(input logic [2:0] h);
		unique case (h)
			3'h4:    bcd_dec60 = {1'b1, 3'h0};
			3'h6:    bcd_dec60 = {1'b1, 3'h1};
			3'h7:    bcd_dec60 = {1'b1, 3'h2};
			3'h3:    bcd_dec60 = {1'b1, 3'h3};
			3'h1:    bcd_dec60 = {1'b1, 3'h4};
			3'h0:    bcd_dec60 = {1'b1, 3'h5};
			default: bcd_dec60 = {1'b0, BCD_SECT_NONE};
		endcase
	endfunction

	function automatic logic [3:0] bcd_dec120(input logic [2:0] h);
		unique case (h)
			3'h4:    bcd_dec120 = {1'b1, 3'h0};
			3'h6:    bcd_dec120 = {1'b1, 3'h1};
			3'h2:    bcd_dec120 = {1'b1, 3'h2};
			3'h3:    bcd_dec120 = {1'b1, 3'h3};
			3'h1:    bcd_dec120 = {1'b1, 3'h4};
			3'h5:    bcd_dec120 = {1'b1, 3'h5};
			default: bcd_dec120 = {1'b0, BCD_SECT_NONE};
		endcase
	endfunction

	// ==========================================================
	// Input conditioning
	always_comb
	begin
		// Open hall lines read high, like the pull-ups
		hall[2] = hall_a_conn ? hall_input_a : 1'b1;
		hall[1] = hall_b_conn ? hall_input_b : 1'b1;
		hall[0] = hall_c_conn ? hall_input_c : 1'b1;
		use_sw  = st_r.ctrl[BCD_CTRL_USE_BIT];
		// Pins win unless software takes over; open enable and brake pins default high
		en_eff  = use_sw ? st_r.ctrl[BCD_CTRL_EN_BIT]
			: (run_enable_conn ? run_enable : 1'b1);
		brk_eff = use_sw ? st_r.ctrl[BCD_CTRL_BRK_BIT]
			: (brake_conn ? brake_in : 1'b1);
		dir_eff = use_sw ? st_r.ctrl[BCD_CTRL_DIR_BIT] : forward_sel;
		sel_eff = use_sw ? st_r.ctrl[BCD_CTRL_SEL_BIT] : phasing_60_sel;
		{valid, sect} = sel_eff ? bcd_dec60(hall) : bcd_dec120(hall);
	end

	// ==========================================================
	// Six-step commutation
	always_comb
	begin
		top_on = '0;
		bot_on = '0;
		// Each sector: one top and one bottom on different phases
		unique case (sect)
			3'h0:    begin top_on.a = 1'b1; bot_on.c = 1'b1; end
			3'h1:    begin top_on.b = 1'b1; bot_on.c = 1'b1; end
			3'h2:    begin top_on.b = 1'b1; bot_on.a = 1'b1; end
			3'h3:    begin top_on.c = 1'b1; bot_on.a = 1'b1; end
			3'h4:    begin top_on.c = 1'b1; bot_on.b = 1'b1; end
			3'h5:    begin top_on.a = 1'b1; bot_on.b = 1'b1; end
			default: begin top_on = '0; bot_on = '0; end
		endcase
		// Reverse: exchange top and bottom of the same phase
		if (!dir_eff)
		begin
			{top_on, bot_on} = {bot_on, top_on};
		end
	end

	// ==========================================================
	// Drive selection and fault
	always_comb
	begin
		// Latched until next oscillator cycle start
		oc_now    = prot.overcurrent | st_r.oc_latch;
		fault_now = !valid | !en_eff | prot.overcurrent
			| prot.undervoltage | prot.overtemp;
		if (brk_eff)
		begin
			top_n_int = BCD_TOP_ALL_OFF;
			// Bottoms held off until the internal top controls are off
			bot_int   = (st_r.drv.top_n == BCD_TOP_ALL_OFF)
				? BCD_BOT_ALL_ON : BCD_BOT_ALL_OFF;
		end
		else if (!en_eff)
		begin
			top_n_int = BCD_TOP_ALL_OFF;
			bot_int   = BCD_BOT_ALL_OFF;
		end
		else if (!valid)
		begin
			top_n_int = BCD_TOP_ALL_OFF;
			bot_int   = BCD_BOT_ALL_OFF;
		end
		else if (oc_now || prot.undervoltage || prot.overtemp)
		begin
			top_n_int = BCD_TOP_ALL_OFF;
			bot_int   = BCD_BOT_ALL_OFF;
		end
		else
		begin
			top_n_int = ~top_on;
			bot_int   = bot_on;
		end
	end

	// ==========================================================
	// Next state and bus slave
	always_comb
	begin
		st_nxt             = st_r;
		st_nxt.drv.top_n   = top_n_int;
		st_nxt.drv.bot     = bot_int;
		st_nxt.drv.fault_n = !fault_now;
		st_nxt.sector      = valid ? sect : BCD_SECT_NONE;
		st_nxt.invalid     = !valid;
		// Set wins over the cycle-start clear
		st_nxt.oc_latch    = prot.overcurrent | (st_r.oc_latch & !osc_cycle_start);
		// One wait cycle, then answer; ack drops for one cycle after
		bus_go             = (avs_read | avs_write) & !st_r.ack;
		st_nxt.ack         = bus_go;
		if (bus_go && avs_write && avs_address == BCD_OFS_CTRL && avs_byteenable[0])
		begin
			st_nxt.ctrl = avs_writedata[4:0];
		end
		st_nxt.rdata = '0;
		if (bus_go && avs_read)
		begin
			unique case (avs_address)
				BCD_OFS_CTRL:   st_nxt.rdata = {27'h0, st_r.ctrl};
				BCD_OFS_STATUS: st_nxt.rdata = {25'h0, st_r.sector, 2'h0,
					st_r.invalid, !st_r.drv.fault_n};
				BCD_OFS_DRIVE:  st_nxt.rdata = {25'h0, st_r.drv};
				default:        st_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r             <= '0;
			st_r.ctrl        <= BCD_CTRL_RESET;
			st_r.sector      <= BCD_SECT_NONE;
			st_r.drv.top_n   <= BCD_TOP_ALL_OFF;
			st_r.drv.bot     <= BCD_BOT_ALL_OFF;
			st_r.drv.fault_n <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	always_comb
	begin
		avs_readdata            = st_r.rdata;
		avs_waitrequest         = !st_r.ack;
		phase_a_high_side_drive = st_r.drv.top_n.a;
		phase_b_high_side_drive = st_r.drv.top_n.b;
		phase_c_high_side_drive = st_r.drv.top_n.c;
		phase_a_low_side_drive  = st_r.drv.bot.a;
		phase_b_low_side_drive  = st_r.drv.bot.b;
		phase_c_low_side_drive  = st_r.drv.bot.c;
		fault_n                 = st_r.drv.fault_n;
	end

endmodule // bcd_decoder

// ### tb/bcd_monitor.sv
/* Checker for the drive pins of bcd_decoder.
   Assumes pin mode (software override off) and the bind at the foot. */
`timescale 1ns/1ps
module bcd_monitor
	import bcd_pkg::*;
(
	input wire logic               clock,
	input wire logic               rstn,
	input wire logic               hall_input_a,
	input wire logic               hall_input_b,
	input wire logic               hall_input_c,
	input wire logic               hall_a_conn,
	input wire logic               hall_b_conn,
	input wire logic               hall_c_conn,
	input wire logic               phasing_60_sel,
	input wire logic               run_enable,
	input wire logic               run_enable_conn,
	input wire logic               brake_in,
	input wire logic               brake_conn,
	input wire bcd_pkg::bcd_prot_t prot,
	input wire logic               phase_a_high_side_drive,
	input wire logic               phase_b_high_side_drive,
	input wire logic               phase_c_high_side_drive,
	input wire logic               phase_a_low_side_drive,
	input wire logic               phase_b_low_side_drive,
	input wire logic               phase_c_low_side_drive,
	input wire logic               fault_n
);
	// ==========================================================
	// Pin levels after open-line defaults
	wire logic       brk = brake_in | ~brake_conn;
	wire logic       en  = run_enable | ~run_enable_conn;
	wire logic [2:0] h   = {hall_input_a | ~hall_a_conn, hall_input_b | ~hall_b_conn, hall_input_c | ~hall_c_conn};
	wire logic       inv = phasing_60_sel ? (h == 3'h2 || h == 3'h5) : (h == 3'h7 || h == 3'h0);
	wire logic [2:0] t   = {phase_a_high_side_drive, phase_b_high_side_drive, phase_c_high_side_drive};
	wire logic [2:0] bo  = {phase_a_low_side_drive, phase_b_low_side_drive, phase_c_low_side_drive};
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// ==========================================================
	// Drive relations, one cycle behind the inputs
	brake_tops_a: assert property (brk |=> t == 3'h7)
		else $error("top drive on while braking");
	brake_bottoms_a: assert property (brk [*2] |=> bo == 3'h7)
		else $error("bottoms not all on while braking");
	brake_wait_a: assert property ($rose(&bo) |-> $past(t) == 3'h7)
		else $error("bottoms on before tops were off");
	no_shoot_a: assert property ((~t & bo) == 3'h0)
		else $error("top and bottom of one phase both on");
	coast_a: assert property (!en && !brk |=> t == 3'h7 && bo == 3'h0 && !fault_n)
		else $error("disabled drive not coasting");
	bad_code_a: assert property (inv && !brk |=> t == 3'h7 && bo == 3'h0 && !fault_n)
		else $error("invalid code not blocked");
	over_current_a: assert property (prot.overcurrent && !brk |=> bo == 3'h0 && !fault_n)
		else $error("overcurrent left bottoms on");
	supply_fault_a: assert property (prot.undervoltage || prot.overtemp |=> !fault_n)
		else $error("supply or thermal fault not flagged");
	one_step_a: assert property (fault_n && t != 3'h7 |-> $onehot(~t) && $onehot(bo))
		else $error("running step not one top and one bottom");
endmodule // bcd_monitor

bind bcd_decoder bcd_monitor u_mon (.clock(clock), .rstn(rstn), .hall_input_a(hall_input_a),
	.hall_input_b(hall_input_b), .hall_input_c(hall_input_c), .hall_a_conn(hall_a_conn),
	.hall_b_conn(hall_b_conn), .hall_c_conn(hall_c_conn), .phasing_60_sel(phasing_60_sel),
	.run_enable(run_enable), .run_enable_conn(run_enable_conn), .brake_in(brake_in), .brake_conn(brake_conn),
	.prot(prot), .phase_a_high_side_drive(phase_a_high_side_drive),
	.phase_b_high_side_drive(phase_b_high_side_drive), .phase_c_high_side_drive(phase_c_high_side_drive),
	.phase_a_low_side_drive(phase_a_low_side_drive), .phase_b_low_side_drive(phase_b_low_side_drive),
	.phase_c_low_side_drive(phase_c_low_side_drive), .fault_n(fault_n));

// ### tb/bcd_hall_model.sv
/* Hall sensor model: code of a rotor sector for either phasing.
   Assumes sectors 6 and 7 stand for the two broken-sensor codes. */
`timescale 1ns/1ps
module bcd_hall_model
(
	input  wire logic [2:0] sector,
	input  wire logic       sel60,
	output logic [2:0]      code
);
	// ==========================================================
	// Sector to sensor code
	always_comb
	begin
		case (sector)
			3'h0: code = 3'h4;
			3'h1: code = 3'h6;
			3'h2: code = sel60 ? 3'h7 : 3'h2;
			3'h3: code = 3'h3;
			3'h4: code = 3'h1;
			3'h5: code = sel60 ? 3'h0 : 3'h5;
			3'h6: code = sel60 ? 3'h2 : 3'h7;
			default: code = sel60 ? 3'h5 : 3'h0;
		endcase
	end
endmodule // bcd_hall_model

// ### tb/tb_bcd_decoder.sv
/* Testbench for bcd_decoder: pin stimulus through a sensor model, Avalon access.
   Assumes bcd_monitor is bound to the design. */
`timescale 1ns/1ps
module tb_bcd_decoder;
	import bcd_pkg::*;
	logic        clock = 1'h0, rstn = 1'h0, sel = 1'h1, fwd = 1'h1, en = 1'h1, en_conn = 1'h1;
	logic        brk = 1'h0, brk_conn = 1'h1, osc = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic [2:0]  sector = 3'h0, conn = 3'h7;
	logic [3:0]  avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, rd;
	bcd_prot_t   prot = 3'h0;
	wire logic [31:0] avs_readdata;
	wire logic        avs_waitrequest, fault_n;
	wire logic [2:0]  code, t, b;
	wire logic [6:0]  drv = {t, b, fault_n};
	int          bad_count = 0, n_tests = 0, i, j, k;
	// Forward step per sector: tops_n a,b,c then bottoms a,b,c
	logic [5:0]  fwd_tab [6] = '{6'h19, 6'h29, 6'h2c, 6'h34, 6'h32, 6'h1a};
	always #50 clock = ~clock;
	bcd_hall_model u_hall (.sector(sector), .sel60(sel), .code(code));
	bcd_decoder u_dut (.clock(clock), .rstn(rstn), .hall_input_a(code[2]), .hall_input_b(code[1]),
		.hall_input_c(code[0]), .hall_a_conn(conn[2]), .hall_b_conn(conn[1]), .hall_c_conn(conn[0]),
		.phasing_60_sel(sel), .forward_sel(fwd), .run_enable(en), .run_enable_conn(en_conn), .brake_in(brk),
		.brake_conn(brk_conn), .osc_cycle_start(osc), .prot(prot), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .phase_a_high_side_drive(t[2]),
		.phase_b_high_side_drive(t[1]), .phase_c_high_side_drive(t[0]), .phase_a_low_side_drive(b[2]),
		.phase_b_low_side_drive(b[1]), .phase_c_low_side_drive(b[0]), .fault_n(fault_n));
	// ==========================================================
	// Compare, bus and step helpers
	task automatic cmp_bus(input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_drv(input logic [6:0] e);
		cmp_bus({25'h0, e}, {25'h0, drv});
	endtask
	// Called just after an edge; holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0 && n < 20)
		begin
			@(posedge clock);
			n++;
		end
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (n == 20) bad_count++;
		@(posedge clock);
	endtask
	task automatic run(input logic [2:0] s, input logic [6:0] e);
		sector <= s;
		repeat (3) @(posedge clock);
		cmp_drv(e);
	endtask
	function automatic logic [6:0] step(input int s, input logic f);
		return f ? {fwd_tab[s], 1'h1} : {~fwd_tab[s][2:0], ~fwd_tab[s][5:3], 1'h1};
	endfunction
	task automatic report_and_stop;
		if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clock);
		rstn <= 1'h1;
		@(posedge clock);
		bus(1'h0, BCD_OFS_CTRL, 32'h0);
		cmp_bus({27'h0, BCD_CTRL_RESET}, rd);
		bus(1'h1, BCD_OFS_CTRL, 32'h7);
		bus(1'h0, BCD_OFS_CTRL, 32'h0);
		cmp_bus(32'h7, rd);
		bus(1'h0, 4'hc, 32'h0);
		cmp_bus(32'h0, rd);
		for (i = 0; i < 2; i++)
			for (j = 0; j < 2; j++)
				for (k = 0; k < 6; k++)
				begin
					sel <= i[0];
					fwd <= j[0];
					run(k[2:0], step(k, j[0]));
				end
		for (i = 0; i < 2; i++)
		begin
			sel <= i[0];
			run(3'h6, 7'h70);
			run(3'h7, 7'h70);
		end
		fwd <= 1'h1;
		conn <= 3'h6;
		run(3'h6, step(3, 1'h1));
		conn <= 3'h7;
		en <= 1'h0;
		run(3'h0, 7'h70);
		en_conn <= 1'h0;
		run(3'h0, step(0, 1'h1));
		en <= 1'h1;
		en_conn <= 1'h1;
		prot <= 3'h4;
		run(3'h1, 7'h70);
		prot <= 3'h0;
		run(3'h1, 7'h71);
		osc <= 1'h1;
		@(posedge clock);
		osc <= 1'h0;
		run(3'h1, step(1, 1'h1));
		prot <= 3'h2;
		run(3'h1, 7'h70);
		prot <= 3'h1;
		run(3'h1, 7'h70);
		prot <= 3'h0;
		brk <= 1'h1;
		run(3'h2, 7'h7f);
		fwd <= 1'h0;
		run(3'h4, 7'h7f);
		brk <= 1'h0;
		brk_conn <= 1'h0;
		run(3'h0, 7'h7f);
		brk_conn <= 1'h1;
		run(3'h0, step(0, 1'h0));
		bus(1'h0, BCD_OFS_DRIVE, 32'h0);
		cmp_bus({25'h0, step(0, 1'h0)}, rd);
		bus(1'h0, BCD_OFS_STATUS, 32'h0);
		cmp_bus(32'h0, rd);
		// Software override: brake from the register while the pin is low
		bus(1'h1, BCD_OFS_CTRL, 32'h13);
		run(3'h0, 7'h7f);
		bus(1'h1, BCD_OFS_CTRL, {27'h0, BCD_CTRL_RESET});
		run(3'h0, step(0, 1'h0));
		rstn <= 1'h0;
		@(posedge clock);
		cmp_drv(7'h71);
		rstn <= 1'h1;
		run(3'h3, step(3, 1'h0));
		report_and_stop;
	end
	// Whole run is well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clock);
		bad_count++;
		report_and_stop;
	end
endmodule // tb_bcd_decoder
